// [src/clra_pkg.sv]
// Constants and types shared by the character display controller and its host.
// How it works
// - 1xxxxxxx write sets counter, selects display RAM
// - One-line mode: display addresses 00H..4FH contiguous
// - Two-line rows at 00H..27H and 40H..67H
// - Status read: busy on bit7, counter below
// - Host waits until busy reads low
// - Data write stores byte at counter
// - Last address-set picks display or glyph RAM
// - Counter steps by one after write
// - Data read drives selected RAM byte
// - First read without address-set is stale
// - Cursor shift in display RAM reloads output register
// - Counter steps by one after read
// - Host avoids display shift after glyph read
// - Read after write returns previously latched data
// - Step bit high increments, low decrements
// - Dual row bit high means two lines
// - 01xxxxxx write sets glyph address, selects glyph
// - Busy lasts 37us address-set, 43us data
package clra_pkg;
   localparam int  CLK_MHZ         = 200;
   localparam int  ADDR_SET_NS     = 37000;
   localparam int  DATA_ACC_NS     = 43000;
   localparam int  ADDR_SET_CYC    = (ADDR_SET_NS * CLK_MHZ + 999) / 1000;
   localparam int  DATA_ACC_CYC    = (DATA_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int  OTHER_CMD_CYC   = ADDR_SET_CYC;
   localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
   localparam logic [6:0] ROW0_LAST     = 7'h27;
   localparam logic [6:0] ROW1_FIRST    = 7'h40;
   localparam logic [6:0] ROW1_LAST     = 7'h67;
   localparam int  DDR_BIT         = 7;
   localparam int  CGR_BIT         = 6;
   localparam int  BUSY_BIT        = 7;
   localparam logic [7:0] SHIFT_MASK    = 8'hf0;
   localparam logic [7:0] SHIFT_CODE    = 8'h10;
   localparam int  SHIFT_SC_BIT    = 3;
   localparam int  SHIFT_RL_BIT    = 2;
   localparam logic [7:0] ENTRY_MASK    = 8'hfc;
   localparam logic [7:0] ENTRY_CODE    = 8'h04;
   localparam int  ENTRY_ID_BIT    = 1;
   localparam logic [7:0] FUNC_MASK     = 8'he0;
   localparam logic [7:0] FUNC_CODE     = 8'h20;
   localparam int  FUNC_N_BIT      = 3;
   localparam logic STEP_UP_RST    = 1'b1;
   localparam logic DUAL_ROW_RST   = 1'b0;
   typedef enum logic [1:0] {CLRA_OP_CMD, CLRA_OP_STATUS, CLRA_OP_WRITE, CLRA_OP_READ} clra_op_t;
endpackage : clra_pkg

// [src/clra_bus_if.sv]
// Parallel instruction bus joining host and display controller.
interface clra_bus_if;
   logic       reg_sel;
   logic       rd_not_wr;
   logic       strobe;
   logic [7:0] bus_lines_host;
   logic [7:0] bus_lines_dev;
   logic       bus_lines_dev_oe_n;
   logic [7:0] bus_lines;
   assign bus_lines = bus_lines_dev_oe_n ? bus_lines_host : bus_lines_dev;
   modport device (input reg_sel, input rd_not_wr, input strobe, input bus_lines_host,
                   output bus_lines_dev, output bus_lines_dev_oe_n);
   modport host   (output reg_sel, output rd_not_wr, output strobe, output bus_lines_host,
                   input bus_lines_dev, input bus_lines_dev_oe_n);
endinterface : clra_bus_if

// [src/clra_device.sv]
// Display controller end: address counter, display and glyph RAM, busy timing.
module clra_device #(
   parameter int ADDR_SET_CYC  = clra_pkg::ADDR_SET_CYC,
   parameter int DATA_ACC_CYC  = clra_pkg::DATA_ACC_CYC,
   parameter int OTHER_CMD_CYC = clra_pkg::OTHER_CMD_CYC
) (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // Instruction bus
   clra_bus_if.device      bus,
   // Display state for the panel driver
   output logic [6:0]      address_counter_o,
   output logic            dual_row_o,
   output logic            glyph_sel_o
);
   localparam int CW = $clog2(DATA_ACC_CYC + 1) + 1;

   logic [7:0]    ddr_mem [0:127];
   logic [7:0]    cgr_mem [0:63];
   logic [6:0]    address_counter;
   logic          glyph_sel;
   logic          step_up;
   logic          dual_row;
   logic [7:0]    out_data;
   logic          out_valid;
   logic [CW-1:0] busy_cnt;
   logic          busy_flag;
   logic          strobe_q;
   logic [7:0]    dout;
   logic          dout_oe_n;
   logic [6:0]    next_step;
   logic [6:0]    next_shift;
   logic [6:0]    next_set;
   logic          take;
   logic          is_cmd_wr;
   logic          is_status;
   logic          is_write;
   logic          is_read;
   logic          is_shift;
   logic [7:0]    din;

   assign din       = bus.bus_lines_host;
   assign take      = bus.strobe && !strobe_q;
   assign is_cmd_wr = take && !bus.reg_sel && !bus.rd_not_wr && !busy_flag;
   assign is_status = take && !bus.reg_sel && bus.rd_not_wr;
   assign is_write  = take && bus.reg_sel && !bus.rd_not_wr && !busy_flag;
   assign is_read   = take && bus.reg_sel && bus.rd_not_wr && !busy_flag;
   assign is_shift  = is_cmd_wr && ((din & clra_pkg::SHIFT_MASK) == clra_pkg::SHIFT_CODE)
                      && !din[clra_pkg::SHIFT_SC_BIT];

   // Wrap a stepped address back into the legal display range for the row mode, or into 00H..3FH in glyph RAM
   function automatic logic [6:0] clra_wrap(input logic [6:0] a, input logic up, input logic dual,
                                            input logic glyph);
      logic [6:0] n;
      n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
      if (glyph) begin
         n = {1'b0, n[5:0]};
      end else if (!dual) begin
         if (up && a == clra_pkg::ONE_LINE_LAST) n = 7'h00;
         else if (!up && a == 7'h00) n = clra_pkg::ONE_LINE_LAST;
      end else begin
         if (up && a == clra_pkg::ROW0_LAST) n = clra_pkg::ROW1_FIRST;
         else if (up && a == clra_pkg::ROW1_LAST) n = 7'h00;
         else if (!up && a == clra_pkg::ROW1_FIRST) n = clra_pkg::ROW0_LAST;
         else if (!up && a == 7'h00) n = clra_pkg::ROW1_LAST;
      end
      return n;
   endfunction : clra_wrap

   always_comb begin
      next_step  = clra_wrap(address_counter, step_up, dual_row, glyph_sel);
      next_shift = clra_wrap(address_counter, din[clra_pkg::SHIFT_RL_BIT], dual_row, glyph_sel);
      if (din[clra_pkg::DDR_BIT]) next_set = din[6:0];
      else next_set = {1'b0, din[5:0]};
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) strobe_q <= 1'b0;
      else strobe_q <= bus.strobe;
   end

   // Address counter and RAM selection; status reads leave both untouched
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         address_counter <= 7'h00;
         glyph_sel       <= 1'b0;
      end else if (is_cmd_wr && (din[clra_pkg::DDR_BIT] || din[clra_pkg::CGR_BIT])) begin
         address_counter <= next_set;
         glyph_sel       <= !din[clra_pkg::DDR_BIT];
      end else if (is_shift) begin
         address_counter <= next_shift;
      end else if (is_write || is_read) begin
         address_counter <= next_step;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         step_up  <= clra_pkg::STEP_UP_RST;
         dual_row <= clra_pkg::DUAL_ROW_RST;
      end else if (is_cmd_wr && (din & clra_pkg::ENTRY_MASK) == clra_pkg::ENTRY_CODE) begin
         step_up <= din[clra_pkg::ENTRY_ID_BIT];
      end else if (is_cmd_wr && (din & clra_pkg::FUNC_MASK) == clra_pkg::FUNC_CODE) begin
         dual_row <= din[clra_pkg::FUNC_N_BIT];
      end
   end

   // RAM arrays need no reset; contents are undefined until written
   always_ff @(posedge core_clk_i) begin
      if (is_write && !glyph_sel) ddr_mem[address_counter] <= din;
      if (is_write && glyph_sel) cgr_mem[address_counter[5:0]] <= din;
   end

   // Output data register: loaded by address-set, cursor shift in display RAM, or a read.
   // A read hands out the latched byte and then prefetches from the stepped address.
   // A write only invalidates, so the following read is stale by design.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         out_data  <= 8'h00;
         out_valid <= 1'b0;
      end else if (is_cmd_wr && din[clra_pkg::DDR_BIT]) begin
         out_data  <= ddr_mem[din[6:0]];
         out_valid <= 1'b1;
      end else if (is_cmd_wr && din[clra_pkg::CGR_BIT]) begin
         out_data  <= cgr_mem[din[5:0]];
         out_valid <= 1'b1;
      end else if (is_shift && !glyph_sel) begin
         out_data  <= ddr_mem[next_shift];
         out_valid <= 1'b1;
      end else if (is_read) begin
         out_data  <= glyph_sel ? cgr_mem[next_step[5:0]] : ddr_mem[next_step];
         out_valid <= 1'b1;
      end else if (is_write) begin
         out_valid <= 1'b0;
      end
   end

   // Busy counter; status reads never start it
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         busy_cnt  <= '0;
         busy_flag <= 1'b0;
      end else if (is_cmd_wr) begin
         busy_flag <= 1'b1;
         if (din[clra_pkg::DDR_BIT] || din[clra_pkg::CGR_BIT])
            busy_cnt <= CW'(ADDR_SET_CYC - 1);
         else
            busy_cnt <= CW'(OTHER_CMD_CYC - 1);
      end else if (is_write || is_read) begin
         busy_flag <= 1'b1;
         busy_cnt  <= CW'(DATA_ACC_CYC - 1);
      end else if (busy_cnt != '0) begin
         busy_cnt <= busy_cnt - 1'b1;
      end else begin
         busy_flag <= 1'b0;
      end
   end

   // Read driver: bus lines driven while a read strobe is high
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         dout      <= 8'h00;
         dout_oe_n <= 1'b1;
      end else if (bus.strobe && bus.rd_not_wr) begin
         dout_oe_n <= 1'b0;
         if (!bus.reg_sel) dout <= {busy_flag, address_counter};
         else if (take) dout <= out_data;
      end else begin
         dout_oe_n <= 1'b1;
      end
   end

   assign bus.bus_lines_dev      = dout;
   assign bus.bus_lines_dev_oe_n = dout_oe_n;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         address_counter_o <= 7'h00;
         dual_row_o        <= clra_pkg::DUAL_ROW_RST;
         glyph_sel_o       <= 1'b0;
      end else begin
         address_counter_o <= address_counter;
         dual_row_o        <= dual_row;
         glyph_sel_o       <= glyph_sel;
      end
   end
endmodule : clra_device

// [src/clra_host.sv]
// Host end: turns one user request into a busy-polled bus cycle.
module clra_host #(
   parameter int STROBE_CYC = 2
) (
   // Clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   // User request
   input  wire logic                 req_i,
   input  wire clra_pkg::clra_op_t   op_i,
   input  wire logic [7:0]           wdata_i,
   output logic                      ready_o,
   output logic                      done_o,
   output logic [7:0]                rdata_o,
   // Instruction bus
   clra_bus_if.host                  bus
);
   typedef enum {CLRA_H_IDLE, CLRA_H_POLL, CLRA_H_POLL_END, CLRA_H_ACC, CLRA_H_ACC_END} clra_hstate_t;

   clra_hstate_t       state;
   clra_pkg::clra_op_t op;
   logic [7:0]         wdata;
   logic [3:0]         cnt;
   logic               reg_sel;
   logic               rd_not_wr;
   logic               strobe;

   assign bus.reg_sel        = reg_sel;
   assign bus.rd_not_wr      = rd_not_wr;
   assign bus.strobe         = strobe;
   assign bus.bus_lines_host = wdata;

   // Every access is preceded by a status poll until busy reads low
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state     <= CLRA_H_IDLE;
         op        <= clra_pkg::CLRA_OP_CMD;
         wdata     <= 8'h00;
         cnt       <= 4'h0;
         reg_sel   <= 1'b0;
         rd_not_wr <= 1'b1;
         strobe    <= 1'b0;
         ready_o   <= 1'b1;
         done_o    <= 1'b0;
         rdata_o   <= 8'h00;
      end else begin
         done_o <= 1'b0;
         case (state)
            CLRA_H_IDLE: begin
               if (req_i) begin
                  op        <= op_i;
                  wdata     <= wdata_i;
                  ready_o   <= 1'b0;
                  reg_sel   <= 1'b0;
                  rd_not_wr <= 1'b1;
                  strobe    <= 1'b1;
                  cnt       <= 4'(STROBE_CYC);
                  state     <= CLRA_H_POLL;
               end
            end
            CLRA_H_POLL: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  strobe <= 1'b0;
                  state  <= CLRA_H_POLL_END;
                  if (bus.bus_lines_dev[clra_pkg::BUSY_BIT]) cnt <= 4'h0;
                  else cnt <= 4'h1;
               end
            end
            CLRA_H_POLL_END: begin
               if (cnt == 4'h0 || op == clra_pkg::CLRA_OP_STATUS) begin
                  if (op == clra_pkg::CLRA_OP_STATUS && cnt != 4'h0) begin
                     rdata_o <= bus.bus_lines_dev;
                     done_o  <= 1'b1;
                     ready_o <= 1'b1;
                     state   <= CLRA_H_IDLE;
                  end else begin
                     strobe <= 1'b1;
                     cnt    <= 4'(STROBE_CYC);
                     state  <= CLRA_H_POLL;
                  end
               end else begin
                  reg_sel   <= op == clra_pkg::CLRA_OP_WRITE || op == clra_pkg::CLRA_OP_READ;
                  rd_not_wr <= op == clra_pkg::CLRA_OP_READ;
                  strobe    <= 1'b1;
                  cnt       <= 4'(STROBE_CYC);
                  state     <= CLRA_H_ACC;
               end
            end
            CLRA_H_ACC: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  strobe  <= 1'b0;
                  rdata_o <= bus.bus_lines_dev;
                  state   <= CLRA_H_ACC_END;
               end
            end
            CLRA_H_ACC_END: begin
               reg_sel   <= 1'b0;
               rd_not_wr <= 1'b1;
               done_o    <= 1'b1;
               ready_o   <= 1'b1;
               state     <= CLRA_H_IDLE;
            end
            default: state <= CLRA_H_IDLE;
         endcase
      end
   end
endmodule : clra_host

// [bench/clra_checker.sv]
// Concurrent checks on the instruction bus between host and display controller.
module clra_checker #(
   parameter int ADDR_SET_CYC = 20,
   parameter int DATA_ACC_CYC = 24
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       reg_sel,
   input  wire logic       rd_not_wr,
   input  wire logic       strobe,
   input  wire logic [7:0] bus_lines_host,
   input  wire logic [7:0] bus_lines_dev,
   input  wire logic       bus_lines_dev_oe_n,
   input  wire logic [7:0] bus_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BUSY_MIN = ADDR_SET_CYC - 1;
   localparam int BUSY_MAX = DATA_ACC_CYC + 3;
   logic strobe_q;
   logic last_busy;
   int   since_cmd;
   logic stat_drv;
   assign stat_drv = strobe && !reg_sel && rd_not_wr && !bus_lines_dev_oe_n;

   always_ff @(posedge core_clk_i) begin
      strobe_q <= rst_i ? 1'b0 : strobe;
   end
   // Last busy value the host saw; any access started while it was high breaks the poll loop
   always_ff @(posedge core_clk_i) begin
      if (rst_i) last_busy <= 1'b0;
      else if (stat_drv) last_busy <= bus_lines[7];
   end
   // Saturates so a long idle spell cannot wrap the count
   always_ff @(posedge core_clk_i) begin
      if (rst_i) since_cmd <= 1000;
      else if (strobe && !strobe_q && !(!reg_sel && rd_not_wr)) since_cmd <= 0;
      else if (since_cmd < 1000) since_cmd <= since_cmd + 1;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_poll_before_access: assert property ($rose(strobe) && !(!reg_sel && rd_not_wr) |-> !last_busy)
      else $error("access started while busy was seen high");
   a_read_drives_bus: assert property ($rose(strobe) && rd_not_wr |-> ##[1:2] !bus_lines_dev_oe_n)
      else $error("device did not drive a read");
   a_write_no_drive: assert property (strobe && $past(strobe) && !rd_not_wr |-> bus_lines_dev_oe_n)
      else $error("device drove the bus during a write");
   a_idle_release: assert property (!strobe [*2] |-> bus_lines_dev_oe_n)
      else $error("device kept driving after the strobe fell");
   a_status_counter_stable: assert property (stat_drv && $past(stat_drv) |-> $stable(bus_lines[6:0]))
      else $error("counter moved during a status read");
   a_host_holds_write: assert property (strobe && $past(strobe) && !rd_not_wr |-> $stable(bus_lines_host))
      else $error("host changed write data mid-strobe");
   a_ctrl_held: assert property (strobe && $past(strobe) |-> $stable(reg_sel) && $stable(rd_not_wr))
      else $error("select or direction changed mid-strobe");
   a_strobe_width: assert property ($rose(strobe) |-> strobe [*2])
      else $error("strobe shorter than two cycles");
   a_busy_too_short: assert property (stat_drv && $past(stat_drv) && !bus_lines[7] |-> since_cmd >= BUSY_MIN)
      else $error("busy cleared before the execution time");
   a_busy_too_long: assert property (stat_drv && $past(stat_drv) && bus_lines[7] |-> since_cmd <= BUSY_MAX)
      else $error("busy held past the execution time");

   c_busy_seen: cover property (stat_drv && bus_lines[7]);
   c_data_read: cover property ($rose(strobe) && reg_sel && rd_not_wr);
   c_data_write: cover property ($rose(strobe) && reg_sel && !rd_not_wr);
endmodule : clra_checker

// [bench/char_lcd_ram_access_instr_tb.sv]
// Testbench: host and controller joined back to back, driven from the host user side.
module char_lcd_ram_access_instr_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic               core_clk_i = 1'b0;
   logic               rst_i      = 1'b1;
   logic               req_i      = 1'b0;
   clra_pkg::clra_op_t op_i       = clra_pkg::CLRA_OP_STATUS;
   logic [7:0]         wdata_i    = 8'h00;
   logic               ready_o;
   logic               done_o;
   logic [7:0]         rdata_o;
   logic [6:0]         address_counter_o;
   logic               dual_row_o;
   logic               glyph_sel_o;
   int                 failures   = 0;
   int                 compares   = 0;
   clra_bus_if bus ();

   clra_host clra_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i), .op_i(op_i),
      .wdata_i(wdata_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .bus(bus.host));
   // Short busy counts keep the run small; the checker gets the same figures
   clra_device #(.ADDR_SET_CYC(20), .DATA_ACC_CYC(24), .OTHER_CMD_CYC(20)) clra_device_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .bus(bus.device), .address_counter_o(address_counter_o),
      .dual_row_o(dual_row_o), .glyph_sel_o(glyph_sel_o));
   clra_checker #(.ADDR_SET_CYC(20), .DATA_ACC_CYC(24)) clra_checker_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .reg_sel(bus.reg_sel), .rd_not_wr(bus.rd_not_wr), .strobe(bus.strobe), .bus_lines_host(bus.bus_lines_host),
      .bus_lines_dev(bus.bus_lines_dev), .bus_lines_dev_oe_n(bus.bus_lines_dev_oe_n), .bus_lines(bus.bus_lines));

   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   task automatic tally_and_finish();
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One user request, waited on under a bound
   task automatic acc(input clra_pkg::clra_op_t op, input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 2000) begin
         @(posedge core_clk_i);
         n++;
      end
      req_i   <= 1'b1;
      op_i    <= op;
      wdata_i <= wd;
      @(posedge core_clk_i);
      req_i <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         failures++;
         $display("[ERR] done_o expected 1 seen timeout");
      end
      rd = rdata_o;
   endtask : acc

   task automatic cmd(input logic [7:0] b);
      logic [7:0] d;
      acc(clra_pkg::CLRA_OP_CMD, b, d);
   endtask : cmd

   task automatic wr(input logic [7:0] b);
      logic [7:0] d;
      acc(clra_pkg::CLRA_OP_WRITE, b, d);
   endtask : wr

   task automatic rd(input logic [7:0] exp);
      logic [7:0] d;
      acc(clra_pkg::CLRA_OP_READ, 8'h00, d);
      chk("read data", exp, d);
   endtask : rd

   // Status byte carries busy on top and the counter below; port copy must agree
   task automatic stat(input logic [6:0] exp);
      logic [7:0] d;
      acc(clra_pkg::CLRA_OP_STATUS, 8'h00, d);
      chk("status", {1'b0, exp}, d);
      chk("address_counter_o", {1'b0, exp}, {1'b0, address_counter_o});
   endtask : stat

   task automatic t_addr_set();
      cmd(8'h85);
      stat(7'h05);
      stat(7'h05);
      chk("glyph_sel_o", 8'h00, {7'h00, glyph_sel_o});
   endtask : t_addr_set

   task automatic t_inc_access();
      cmd(8'h06);
      cmd(8'h85);
      wr(8'ha5);
      wr(8'h3c);
      stat(7'h07);
      cmd(8'h85);
      rd(8'ha5);
      rd(8'h3c);
      stat(7'h07);
   endtask : t_inc_access

   task automatic t_dec_access();
      cmd(8'h04);
      cmd(8'h86);
      wr(8'h11);
      stat(7'h05);
      cmd(8'h86);
      rd(8'h11);
      stat(7'h05);
      cmd(8'h06);
   endtask : t_dec_access

   task automatic t_glyph();
      cmd(8'h7f);
      chk("glyph_sel_o", 8'h01, {7'h00, glyph_sel_o});
      stat(7'h3f);
      wr(8'h77);
      stat(7'h00);
      cmd(8'h7f);
      rd(8'h77);
      cmd(8'h85);
      rd(8'ha5);
   endtask : t_glyph

   task automatic t_rows();
      cmd(8'h38);
      chk("dual_row_o", 8'h01, {7'h00, dual_row_o});
      cmd(8'ha7);
      wr(8'h01);
      stat(7'h40);
      cmd(8'he7);
      wr(8'h02);
      stat(7'h00);
      cmd(8'h30);
      chk("dual_row_o", 8'h00, {7'h00, dual_row_o});
      cmd(8'hcf);
      wr(8'h03);
      stat(7'h00);
   endtask : t_rows

   task automatic t_stale_and_shift();
      cmd(8'h90);
      wr(8'hc3);
      cmd(8'h90);
      wr(8'h5a);
      rd(8'hc3);
      cmd(8'h80);
      wr(8'h21);
      wr(8'h22);
      cmd(8'h80);
      cmd(8'h14);
      rd(8'h22);
      stat(7'h02);
   endtask : t_stale_and_shift

   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_addr_set();
      t_inc_access();
      t_dec_access();
      t_glyph();
      t_rows();
      t_stale_and_shift();
      tally_and_finish();
   end

   // Roughly fifty requests of under a hundred cycles each fit well inside this span
   initial begin
      repeat (20000) @(posedge core_clk_i);
      failures++;
      tally_and_finish();
   end
endmodule : char_lcd_ram_access_instr_tb
